// File: logic/prre_fifo.sv
// Read data FIFO of DWORDs with synchronous flush.
// Assumes pushes only when not full and pops only when count is nonzero.
`timescale 1ns/1ns
module prre_fifo #(
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  prre_fifo_if.store f
);
  import prre_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);
  logic [31:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [4:0] cnt_q;
  logic do_pop;
  logic do_push;

  // Pops on an empty store are dropped so the count cannot wrap.
  assign do_pop = f.pop && (cnt_q != CNT_RST);
  assign do_push = f.push && !f.full;
  assign f.full = (cnt_q == 5'(DEPTH));
  assign f.count = cnt_q;

  // Storage array; no reset needed on the data itself.
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem_q[wr_q] <= f.push_data;
    end
  end

  // Output word registered from the head of the queue.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      f.pop_data <= 32'h0000_0000;
    end else if (f.flush) begin
      f.pop_data <= 32'h0000_0000;
    end else begin
      f.pop_data <= mem_q[rd_q];
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= CNT_RST;
    end else if (f.flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= CNT_RST;
    end else begin
      if (do_push) begin
        wr_q <= AW'(wr_q + 1'b1);
      end
      if (do_pop) begin
        rd_q <= AW'(rd_q + 1'b1);
      end
      cnt_q <= 5'(cnt_q + 5'(do_push) - 5'(do_pop));
    end
  end
endmodule // prre_fifo

// File: logic/prre_fifo_if.sv
// Interface carrying the push and pop sides of the read data FIFO.
// Assumes both sides share one clock.
`timescale 1ns/1ns
interface prre_fifo_if;
  logic push;
  logic [31:0] push_data;
  logic pop;
  logic flush;
  logic [31:0] pop_data;
  logic [4:0] count;
  logic full;
  modport engine (output push, output push_data, output pop, output flush,
    input pop_data, input count, input full);
  modport store (input push, input push_data, input pop, input flush,
    output pop_data, output count, output full);
endinterface // prre_fifo_if

// File: logic/prre_pkg.sv
// Package for the process RAM read engine: register map, fields, reset values.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package prre_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_ADDR_LEN = 12'h308;
  localparam logic [ADDR_W-1:0] OFF_CMD_STAT = 12'h30C;
  localparam logic [ADDR_W-1:0] OFF_FIFO_PORT = 12'h000;
  localparam int unsigned LEN_HI = 31;
  localparam int unsigned LEN_LO = 16;
  localparam int unsigned PTR_HI = 15;
  localparam int unsigned PTR_LO = 0;
  localparam int unsigned BUSY_BIT = 31;
  localparam int unsigned CANCEL_BIT = 30;
  localparam int unsigned CNT_HI = 12;
  localparam int unsigned CNT_LO = 8;
  localparam int unsigned AVAIL_BIT = 0;
  localparam logic [15:0] LEN_RST = 16'h0000;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] PRAM_BASE = 16'h1000;
  localparam logic [15:0] PRAM_LAST = 16'h1FFF;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  localparam logic [1:0] LANE_RST = 2'h0;
  typedef enum logic [1:0] {PRRE_IDLE, PRRE_FETCH, PRRE_FLUSH} prre_state_type;
endpackage

// File: logic/prre_top.sv
// Process RAM read engine: APB registers, byte fetcher and read data FIFO.
// Assumes a process RAM port that answers one byte a cycle after a request.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module prre_top (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [prre_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic pram_req_out,
  output logic [15:0] pram_addr_out,
  input wire logic [7:0] pram_data_in
);
  import prre_pkg::*;

  logic rst_sync_q;
  logic rst_n_q;
  logic [15:0] fetch_byte_count_q;
  logic [15:0] fetch_byte_pointer_q;
  logic fetch_in_progress_q;
  prre_state_type state_q;
  logic [31:0] pack_q;
  logic [1:0] lane_q;
  logic rd_pend_q;
  logic last_pend_q;
  logic apb_wr;
  logic apb_rd;
  logic wr_len;
  logic wr_cmd;
  logic start;
  logic cancel;
  logic last_byte;
  logic fifo_room;
  logic [31:0] packed_word;
  logic fifo_not_empty;
  logic [4:0] fifo_dwords_ready;
  prre_fifo_if fif ();

  // Reset release through two flops; assertion stays asynchronous.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_sync_q <= 1'b1;
      rst_n_q <= rst_sync_q;
    end
  end

  // Zero-wait APB: every access completes in its first access cycle.
  assign pready_out = 1'b1;
  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign apb_rd = psel_in && penable_in && !pwrite_in;
  assign wr_len = apb_wr && (paddr_in == OFF_ADDR_LEN);
  assign wr_cmd = apb_wr && (paddr_in == OFF_CMD_STAT) && pstrb_in[3];
  assign start = wr_cmd && pwdata_in[BUSY_BIT] && !fetch_in_progress_q;
  assign cancel = wr_cmd && pwdata_in[CANCEL_BIT];
  assign last_byte = (fetch_byte_count_q == 16'h0001);

  // The slave never flags an error: unmapped reads give zero and unmapped writes are dropped.
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pslverr_out <= 1'b0;
    end else begin
      pslverr_out <= 1'b0;
    end
  end

  // Live decode of the mapped offsets, kept only as a visible debug net.
  logic mapped;
  assign mapped = (paddr_in == OFF_ADDR_LEN) || (paddr_in == OFF_CMD_STAT)
    || (paddr_in == OFF_FIFO_PORT);

  assign fifo_not_empty = (fif.count != CNT_RST);
  assign fifo_dwords_ready = fif.count;

  // Read data mux; the FIFO word is registered inside the store.
  always_comb begin
    prdata_out = 32'h0000_0000;
    if (apb_rd) begin
      unique case (paddr_in)
        OFF_ADDR_LEN: prdata_out = {fetch_byte_count_q, fetch_byte_pointer_q};
        OFF_CMD_STAT: begin
          prdata_out[BUSY_BIT] = fetch_in_progress_q;
          prdata_out[CNT_HI:CNT_LO] = fifo_dwords_ready;
          prdata_out[AVAIL_BIT] = fifo_not_empty;
        end
        OFF_FIFO_PORT: prdata_out = fif.pop_data;
        default: prdata_out = 32'h0000_0000;
      endcase
    end
  end

  assign fif.pop = apb_rd && (paddr_in == OFF_FIFO_PORT);
  assign fif.flush = cancel;

  // Length and pointer: host writes when idle, the fetcher steps them per byte.
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fetch_byte_count_q <= LEN_RST;
      fetch_byte_pointer_q <= PTR_RST;
    end else if (pram_req_out) begin
      fetch_byte_count_q <= 16'(fetch_byte_count_q - 1'b1);
      fetch_byte_pointer_q <= 16'(fetch_byte_pointer_q + 1'b1);
    end else if (wr_len && !fetch_in_progress_q) begin
      if (pstrb_in[3]) fetch_byte_count_q[15:8] <= pwdata_in[31:24];
      if (pstrb_in[2]) fetch_byte_count_q[7:0] <= pwdata_in[23:16];
      if (pstrb_in[1]) fetch_byte_pointer_q[15:8] <= pwdata_in[15:8];
      if (pstrb_in[0]) fetch_byte_pointer_q[7:0] <= pwdata_in[7:0];
    end
  end

  // Request one byte per cycle while fetching and the FIFO has room.
  // A byte asked for now may close a word that is pushed next cycle, so a push landing
  // this cycle counts against the room; otherwise a word could meet a full store and be lost.
  assign fifo_room = !fif.full && !(fif.count == 5'(FIFO_DEPTH - 1) && fif.push);
  assign pram_req_out = (state_q == PRRE_FETCH) && !cancel && fifo_room;
  assign pram_addr_out = fetch_byte_pointer_q;

  // Sequencer: fetch bytes, then flush a partial final word, then finish.
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= PRRE_IDLE;
      fetch_in_progress_q <= 1'b0;
    end else if (cancel) begin
      state_q <= PRRE_IDLE;
      fetch_in_progress_q <= 1'b0;
    end else begin
      unique case (state_q)
        PRRE_IDLE: if (start) begin
          state_q <= (fetch_byte_count_q == LEN_RST) ? PRRE_IDLE : PRRE_FETCH;
          fetch_in_progress_q <= (fetch_byte_count_q != LEN_RST);
        end
        PRRE_FETCH: if (pram_req_out && last_byte) begin
          state_q <= PRRE_FLUSH;
        end
        PRRE_FLUSH: if (!rd_pend_q) begin
          state_q <= PRRE_IDLE;
          fetch_in_progress_q <= 1'b0;
        end
      endcase
    end
  end

  // little-endian packing of bytes into a word, lane from the address.
  assign packed_word = pack_q | ({24'h000000, pram_data_in} << {lane_q, 3'b000});

  // Byte packer; pushes when a word is full or on the final byte.
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pack_q <= 32'h0000_0000;
      lane_q <= LANE_RST;
      rd_pend_q <= 1'b0;
      last_pend_q <= 1'b0;
    end else if (cancel) begin
      pack_q <= 32'h0000_0000;
      rd_pend_q <= 1'b0;
      last_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= pram_req_out;
      last_pend_q <= pram_req_out && last_byte;
      if (start) begin
        lane_q <= fetch_byte_pointer_q[1:0];
      end else if (rd_pend_q) begin
        lane_q <= 2'(lane_q + 1'b1);
        pack_q <= (lane_q == 2'h3 || last_pend_q) ? 32'h0000_0000 : packed_word;
      end
    end
  end

  assign fif.push = rd_pend_q && (lane_q == 2'h3 || last_pend_q);
  assign fif.push_data = packed_word;

  prre_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_q),
    .f(fif.store)
  );

  // Nets used only for decode visibility.
  logic unused_ok;
  assign unused_ok = mapped;

  // Reading the FIFO port while it holds words, with no push and no cancel, decrements the count by one.
  property pop_dec_p;
    @(posedge sys_clk_in) disable iff (!rst_n_q)
      (fif.pop && fif.count != CNT_RST && !fif.push && !cancel) |=>
      fif.count == $past(fif.count) - 5'h01;
  endproperty
  pop_count_down_a: assert property (pop_dec_p)
    else $error("count did not fall on pop");
  flag_tracks_count_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q)
    (fif.push && !cancel) |=> fifo_not_empty)
    else $error("available flag wrong");
  cancel_clears_busy_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q)
    cancel |=> !fetch_in_progress_q && fif.count == CNT_RST)
    else $error("cancel did not clear");
  start_sets_busy_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q)
    (start && !cancel && fetch_byte_count_q != LEN_RST) |=> fetch_in_progress_q)
    else $error("start did not set busy");
  len_steps_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q)
    pram_req_out |=> fetch_byte_count_q == $past(fetch_byte_count_q) - 16'h0001)
    else $error("length not decremented");
  ptr_steps_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q)
    pram_req_out |=> fetch_byte_pointer_q == $past(fetch_byte_pointer_q) + 16'h0001)
    else $error("pointer not incremented");
  done_clears_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q)
    (pram_req_out && last_byte) |-> ##[1:40] !fetch_in_progress_q)
    else $error("busy did not self clear");
  push_after_req_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q)
    fif.push |-> $past(pram_req_out))
    else $error("push without fetched byte");
  cnt_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q)
    $rose(rst_n_q) |-> fifo_dwords_ready == CNT_RST)
    else $error("count not zero after reset");
  start_c: cover property (@(posedge sys_clk_in) start);
  cancel_busy_c: cover property (@(posedge sys_clk_in) cancel && fetch_in_progress_q);
  full_c: cover property (@(posedge sys_clk_in) fif.full);
  pop_c: cover property (@(posedge sys_clk_in) fif.pop && fifo_not_empty);
endmodule // prre_top

// File: verif/process_ram_read_engine_tb.sv
// Self-checking bench for the process RAM read engine, driven over APB.
// Assumes a zero-wait APB slave and the process RAM model on the fetch port.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module process_ram_read_engine_tb;
  import prre_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic pready;
  logic pslverr;
  logic req;
  logic [15:0] ram_a;
  logic [7:0] ram_d;
  int num_errors = 0;
  int tests_run = 0;
  integer seed = 32'h7115;
  logic [63:0] q[$];
  logic [63:0] note;

  prre_top i_dut (.sys_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .pram_req_out(req),
    .pram_addr_out(ram_a), .pram_data_in(ram_d));
  prre_pram_model i_ram (.clk_in(clk), .req_in(req), .addr_in(ram_a), .data_out(ram_d));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end

  // Each finished read takes the oldest note; a zero mask marks a status poll.
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      note = q.pop_front();
      `CHK("pslverr", 1'b0, pslverr)
      if (note[31:0] != 32'h0) begin
        `CHK("prdata", note[63:32] & note[31:0], prdata & note[31:0])
      end
    end
  end

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back({e, m});
    apb(1'b0, a, 32'h0);
  endtask

  // Program, start, wait for the busy flag to drop, then check and drain every word.
  task automatic xfer(input logic [15:0] sa, input logic [15:0] len);
    logic [31:0] w [0:17];
    int n;
    int k;
    n = (len == 16'h0) ? 0 : (sa[1:0] + len + 3) / 4;
    for (k = 0; k < 18; k++) w[k] = 32'h0;
    for (k = 0; k < len; k++) w[(sa[1:0] + k) / 4][8 * ((sa[1:0] + k) % 4) +: 8] = pat(sa + 16'(k));
    apb(1'b1, OFF_ADDR_LEN, {len, sa});
    apb(1'b1, OFF_CMD_STAT, 32'h8000_0000);
    for (k = 0; k < 200 && (k == 0 || rdv[BUSY_BIT]); k++) rd(OFF_CMD_STAT, 32'h0, 32'h0);
    rd(OFF_ADDR_LEN, {16'h0, sa + len}, 32'hFFFF_FFFF);
    rd(OFF_CMD_STAT, {19'h0, n[4:0], 7'h0, n != 0}, 32'hFFFF_FFFF);
    for (k = 0; k < n; k++) begin
      rd(OFF_FIFO_PORT, w[k], 32'hFFFF_FFFF);
      rd(OFF_CMD_STAT, {19'h0, 5'(n - k - 1), 7'h0, k < n - 1}, 32'hFFFF_FFFF);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: reset values, aligned and unaligned runs, random runs, cancel.
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b1, OFF_CMD_STAT, 32'h0);
    apb(1'b1, 12'h104, 32'hFFFF_FFFF);
    rd(OFF_ADDR_LEN, 32'h0, 32'hFFFF_FFFF);
    rd(OFF_CMD_STAT, 32'h0, 32'hFFFF_FFFF);
    rd(12'h104, 32'h0, 32'hFFFF_FFFF);
    xfer(16'h1001, 16'd9);
    xfer(16'h1FFC, 16'd4);
    xfer(16'h1200, 16'd0);
    // random runs kept inside the window
    repeat (4) xfer(16'h1000 + 16'({$random(seed)} % 4000), 16'(1 + {$random(seed)} % 60));
    apb(1'b1, OFF_ADDR_LEN, {16'd80, 16'h1100});
    apb(1'b1, OFF_CMD_STAT, 32'h8000_0000);
    repeat (90) @(posedge clk);
    rd(OFF_CMD_STAT, 32'h8000_1001, 32'hFFFF_FFFF);
    apb(1'b1, OFF_CMD_STAT, 32'h4000_0000);
    rd(OFF_CMD_STAT, 32'h0, 32'hFFFF_FFFF);
    xfer(16'h1103, 16'd6);
    summarize();
  end

  // The run needs under a thousand cycles; a hang is cut off at 20k.
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
endmodule // process_ram_read_engine_tb

// File: verif/prre_pram_model.sv
// Process RAM model on the byte fetch port of the read engine.
// Assumes one byte request a cycle, answered on the next clock edge.
`timescale 1ns/1ns
module prre_pram_model (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic [15:0] addr_in,
  output logic [7:0] data_out
);
  logic [7:0] data_q = 8'h00;

  // Each byte answers with a pattern of its address, so order slips show.
  // Idle cycles invert the bus, so a stale byte never passes for fresh data.
  always @(posedge clk_in) begin
    if (req_in) begin
      data_q <= addr_in[7:0] ^ addr_in[15:8] ^ 8'hA5;
    end else begin
      data_q <= ~data_q;
    end
  end

  assign data_out = data_q;
endmodule // prre_pram_model
